// File: rse_pkg.sv
// Package: widths, sizes, types and states of the register frame engine
package rse_pkg;
   localparam int PHYS_REGS   = 64;
   localparam int PHYS_W      = 6;
   localparam int VREG_W      = 6;
   localparam int DATA_W      = 64;
   localparam int FRAME_W     = 7;
   localparam int DEPTH       = 16;
   localparam int DEPTH_W     = 4;
   localparam int MEM_ADDR_W  = 16;
   localparam logic [PHYS_W:0]     PHYS_TOTAL = 7'h40;
   localparam logic [PHYS_W-1:0]   BASE_RST   = 6'h00;
   localparam logic [FRAME_W-1:0]  SIZE_RST   = 7'h00;
   localparam logic [MEM_ADDR_W-1:0] MEM_RST  = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SPILL = 2'b01,
      ST_FILL  = 2'b11
   } eng_state_t;

   // Pipeline request carrier
   typedef struct packed {
      logic                call;
      logic                ret;
      logic                alloc;
      logic [FRAME_W-1:0]  alloc_size;
      logic [FRAME_W-1:0]  out_base;
   } req_t;

   // Memory path carrier
   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [MEM_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
   } mem_req_t;
endpackage

// File: frame_stack.sv
// Frame stack: saved caller base and size per call depth
`timescale 1ns/1ns
`default_nettype none
module frame_stack
   import rse_pkg::*;
(
   input  wire logic                i_clock,
   input  wire logic                i_rst_n,
   input  wire logic                i_push,
   input  wire logic                i_pop,
   input  wire logic [PHYS_W-1:0]   i_base,
   input  wire logic [FRAME_W-1:0]  i_size,
   output logic      [PHYS_W-1:0]   o_base,
   output logic      [FRAME_W-1:0]  o_size,
   output logic                     o_empty
);
   logic [PHYS_W-1:0]  base_mem [DEPTH];
   logic [FRAME_W-1:0] size_mem [DEPTH];
   logic [DEPTH_W:0]   ptr;
   logic [DEPTH_W:0]   next_ptr;

   // Pointer moves by one per push or pop
   always_comb begin
      next_ptr = ptr;
      if (i_push && ptr != DEPTH[DEPTH_W:0]) begin
         next_ptr = ptr + 1'b1;
      end else if (i_pop && ptr != '0) begin
         next_ptr = ptr - 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ptr <= '0;
      end else begin
         ptr <= next_ptr;
      end
   end

   // Entries written by index, one generate slot each
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         always_ff @(posedge i_clock) begin
            if (!i_rst_n) begin
               base_mem[g] <= BASE_RST;
               size_mem[g] <= SIZE_RST;
            end else if (i_push && ptr == g) begin
               base_mem[g] <= i_base;
               size_mem[g] <= i_size;
            end
         end
      end
   endgenerate

   // Top of stack, zero when empty
   assign o_empty = (ptr == '0);
   assign o_base  = o_empty ? BASE_RST : base_mem[DEPTH_W'(ptr - 1'b1)];
   assign o_size  = o_empty ? SIZE_RST : size_mem[DEPTH_W'(ptr - 1'b1)];
endmodule
`default_nettype wire

// File: reg_frame_engine.sv
// Register stack engine: renaming, call/return frames, spill and fill
`timescale 1ns/1ns
`default_nettype none
module reg_frame_engine
   import rse_pkg::*;
(
   input  wire logic                  i_clock,
   input  wire logic                  i_rst_n,
   input  wire req_t                  i_req,
   input  wire logic                  i_idle_spill,
   input  wire logic                  i_idle_fill,
   input  wire logic [VREG_W-1:0]     i_rd_vreg,
   input  wire logic                  i_wr_en,
   input  wire logic [VREG_W-1:0]     i_wr_vreg,
   input  wire logic [DATA_W-1:0]     i_wr_data,
   output logic      [DATA_W-1:0]     o_rd_data,
   output logic                       o_stall,
   output var mem_req_t               o_mem,
   input  wire logic                  i_mem_ack,
   input  wire logic [DATA_W-1:0]     i_mem_rdata,
   output logic      [PHYS_W-1:0]     o_base,
   output logic      [FRAME_W-1:0]    o_dirty
);
   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [DATA_W-1:0]     regs [PHYS_REGS];
   logic [PHYS_W-1:0]     base, next_base;
   logic [FRAME_W-1:0]    size, next_size;
   logic [FRAME_W-1:0]    dirty, next_dirty;    // Resident regs below current frame
   logic [PHYS_W-1:0]     spill_ptr, next_spill_ptr; // Oldest resident physical reg
   logic [MEM_ADDR_W-1:0] mem_top, next_mem_top;
   logic [FRAME_W-1:0]    need, next_need;
   eng_state_t            state, next_state;
   logic                  busy_op, next_busy_op;
   logic                  push, pop;
   logic [PHYS_W-1:0]     pop_base;
   logic [FRAME_W-1:0]    pop_size;
   logic                  fs_empty;
   logic [PHYS_W:0]       free_cnt;
   logic                  fill_wr;
   logic [PHYS_W-1:0]     fill_idx;
   logic [PHYS_W-1:0]     ret_span;

   frame_stack u_frames (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_push  (push),
      .i_pop   (pop),
      .i_base  (base),
      .i_size  (size),
      .o_base  (pop_base),
      .o_size  (pop_size),
      .o_empty (fs_empty)
   );

   // Free count: whole ring less the frame and the resident caller regs
   // Full frame size kept, a 64-entry frame must leave nothing free
   assign free_cnt = PHYS_TOTAL - size - dirty;
   // Caller's locals between its base and ours, measured around the ring
   assign ret_span = base - pop_base;
   assign fill_idx = spill_ptr - 1'b1;
   assign fill_wr  = (state == ST_FILL) && i_mem_ack;

   ////////////////////////////////////////////////////////////////////////////////
   // Control: call, return, alloc and spill/fill sequencing
   always_comb begin
      next_base      = base;
      next_size      = size;
      next_dirty     = dirty;
      next_spill_ptr = spill_ptr;
      next_mem_top   = mem_top;
      next_need      = need;
      next_state     = state;
      next_busy_op   = busy_op;
      push           = 1'b0;
      pop            = 1'b0;
      case (state)
         ST_IDLE: begin
            if (i_req.call) begin
               // Callee frame starts past caller's locals
               push       = 1'b1;
               next_base  = base + i_req.out_base[PHYS_W-1:0];
               next_size  = i_req.alloc_size - i_req.out_base;
               next_dirty = dirty + i_req.out_base;
            end else if (i_req.ret) begin
               pop        = !fs_empty;
               next_base  = pop_base;
               next_size  = pop_size;
               if ({1'b0, ret_span} <= dirty) begin
                  next_dirty = dirty - {1'b0, ret_span};
               end else begin
                  // Caller regs missing: stall and refill
                  next_need    = {1'b0, ret_span} - dirty;
                  next_dirty   = SIZE_RST;
                  next_state   = ST_FILL;
                  next_busy_op = 1'b1;
               end
            end else if (i_req.alloc) begin
               next_size = i_req.alloc_size;
               if ({1'b0, i_req.alloc_size} > {1'b0, size} + free_cnt) begin
                  next_need    = i_req.alloc_size - size - FRAME_W'(free_cnt);
                  next_state   = ST_SPILL;
                  next_busy_op = 1'b1;
               end
            end else if (i_idle_spill && dirty != SIZE_RST) begin
               next_need  = 7'h01;
               next_state = ST_SPILL;
            end else if (i_idle_fill && mem_top != MEM_RST &&
                         free_cnt != '0) begin
               next_need  = 7'h01;
               next_state = ST_FILL;
            end
         end
         ST_SPILL: begin
            if (i_mem_ack) begin
               // Oldest resident goes out at next stack slot
               next_spill_ptr = spill_ptr + 1'b1;
               next_mem_top   = mem_top + 1'b1;
               next_dirty     = dirty - 1'b1;
               next_need      = need - 1'b1;
               if (need == 7'h01) begin
                  next_state   = ST_IDLE;
                  next_busy_op = 1'b0;
               end
            end
         end
         ST_FILL: begin
            if (i_mem_ack) begin
               // Most recently spilled comes back first
               next_spill_ptr = fill_idx;
               next_mem_top   = mem_top - 1'b1;
               if (!busy_op) begin
                  next_dirty = dirty + 1'b1;
               end
               next_need = need - 1'b1;
               if (need == 7'h01) begin
                  next_state   = ST_IDLE;
                  next_busy_op = 1'b0;
               end
            end
         end
         default: begin
            next_state   = ST_IDLE;
            next_busy_op = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         base      <= BASE_RST;
         size      <= SIZE_RST;
         dirty     <= SIZE_RST;
         spill_ptr <= BASE_RST;
         mem_top   <= MEM_RST;
         need      <= SIZE_RST;
         state     <= ST_IDLE;
         busy_op   <= 1'b0;
      end else begin
         base      <= next_base;
         size      <= next_size;
         dirty     <= next_dirty;
         spill_ptr <= next_spill_ptr;
         mem_top   <= next_mem_top;
         need      <= next_need;
         state     <= next_state;
         busy_op   <= next_busy_op;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Physical register file, renamed through the frame base
   genvar r;
   generate
      for (r = 0; r < PHYS_REGS; r++) begin : g_reg
         always_ff @(posedge i_clock) begin
            if (!i_rst_n) begin
               regs[r] <= '0;
            end else if (fill_wr && fill_idx == r) begin
               regs[r] <= i_mem_rdata;
            end else if (i_wr_en && !o_stall && PHYS_W'(base + i_wr_vreg) == r) begin
               regs[r] <= i_wr_data;
            end
         end
      end
   endgenerate

   // Read data registered; index wraps around the ring
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_rd_data <= '0;
      end else begin
         o_rd_data <= regs[PHYS_W'(base + i_rd_vreg)];
      end
   end

   // Stall only for pipeline-caused spill/fill, not background work
   assign o_stall     = busy_op;
   assign o_mem.valid = (state != ST_IDLE);
   assign o_mem.write = (state == ST_SPILL);
   assign o_mem.addr  = (state == ST_SPILL) ? mem_top : mem_top - 1'b1;
   assign o_mem.wdata = regs[spill_ptr];
   assign o_base      = base;
   assign o_dirty     = dirty;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_call_base: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_IDLE && i_req.call)
      |=> base == PHYS_W'($past(base) + $past(i_req.out_base[PHYS_W-1:0])))
      else $error("call did not move base");
   chk_ret_base: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_IDLE && !i_req.call && i_req.ret) |=> base == $past(pop_base))
      else $error("return did not restore base");
   chk_spill_stall: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_IDLE && !i_req.call && !i_req.ret && i_req.alloc &&
       ({1'b0, i_req.alloc_size} + {1'b0, dirty}) > {1'b0, PHYS_TOTAL})
      |=> o_stall && o_mem.valid && o_mem.write)
      else $error("spill without stall");
   chk_fill_stall: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_IDLE && !i_req.call && i_req.ret && {1'b0, ret_span} > dirty)
      |=> o_stall)
      else $error("underflow return not stalled");
   chk_spill_order: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_SPILL && i_mem_ack) |=> mem_top == $past(mem_top) + 1'b1)
      else $error("spill stack order broken");
   chk_fill_order: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_FILL && i_mem_ack)
      |=> mem_top == $past(mem_top) - 1'b1 && spill_ptr == $past(spill_ptr) - 1'b1)
      else $error("fill not last in first out");
   chk_idle_nostall: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_IDLE && !i_req.call && !i_req.ret && !i_req.alloc && i_idle_spill
       && dirty != SIZE_RST) |=> !o_stall)
      else $error("background spill stalled pipe");
   chk_rename_rd: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr_en && !o_stall && !fill_wr)
      ##1 (i_rd_vreg == $past(i_wr_vreg) && base == $past(base))
      |=> o_rd_data == $past(i_wr_data, 2))
      else $error("rename read mismatch");
   cov_spill: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      busy_op && state == ST_SPILL ##1 state == ST_IDLE);
   cov_fill: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      busy_op && state == ST_FILL ##1 state == ST_IDLE);
   cov_call_ret: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      i_req.call ##[1:20] i_req.ret);
endmodule
`default_nettype wire

// File: mem_model.sv
// Backing memory model answering spill and fill requests of the engine
`timescale 1ns/1ns
`default_nettype none
module mem_model
   import rse_pkg::*;
(
   input  wire logic               i_clock,
   input  wire logic               i_rst_n,
   input  wire mem_req_t           i_mem,
   input  wire logic               i_slow,
   output logic                    o_ack,
   output logic      [DATA_W-1:0]  o_rdata
);
   logic [DATA_W-1:0] store [256];
   logic [2:0]        wait_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // One word per ack; read data is scrambled between acks so stale reads show
   always_ff @(posedge i_clock) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (!i_rst_n) begin
         wait_cnt <= 3'h0;
         o_rdata  <= '0;
      end else if (i_mem.valid && !o_ack) begin
         // Slow mode adds wait cycles to stretch the stall
         if (wait_cnt == (i_slow ? 3'h3 : 3'h0)) begin
            wait_cnt <= 3'h0;
            o_ack    <= 1'b1;
            if (i_mem.write) begin
               store[i_mem.addr[7:0]] <= i_mem.wdata;
            end else begin
               o_rdata <= store[i_mem.addr[7:0]];
            end
         end else begin
            wait_cnt <= wait_cnt + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the register frame engine
`timescale 1ns/1ns
`default_nettype none
module testbench
   import rse_pkg::*;
;
   logic              i_clock = 1'b0;
   logic              i_rst_n = 1'b0;
   logic              idle_spill = 1'b0;
   logic              idle_fill = 1'b0;
   logic              wr_en = 1'b0;
   logic              slow = 1'b0;
   logic              bg = 1'b0;
   req_t              req = '0;
   logic [VREG_W-1:0] rd_vreg = '0;
   logic [VREG_W-1:0] wr_vreg = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] mem_rdata;
   logic              mem_ack;
   logic              stall;
   mem_req_t          mem;
   logic [PHYS_W-1:0] base;
   logic [FRAME_W-1:0] dirty;
   int                err_total = 0;
   int                tests_run = 0;
   int                cycles = 0;
   int                spills = 0;
   int                top = 0;
   // Ordinary cases: caller virtual register and the data written to it
   logic [VREG_W-1:0] row_v [4] = '{6'h00, 6'h01, 6'h05, 6'h07};
   logic [DATA_W-1:0] row_d [4] = '{64'h0123456789ABCDEF, 64'hFEDCBA9876543210,
                                    64'hA5A5A5A55A5A5A5A, 64'h00000000FFFFFFFF};

   reg_frame_engine u_reg_frame_engine (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req),
      .i_idle_spill(idle_spill), .i_idle_fill(idle_fill), .i_rd_vreg(rd_vreg),
      .i_wr_en(wr_en), .i_wr_vreg(wr_vreg), .i_wr_data(wr_data), .o_rd_data(rd_data),
      .o_stall(stall), .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
      .o_base(base), .o_dirty(dirty));
   mem_model u_mem_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_mem(mem), .i_slow(slow),
      .o_ack(mem_ack), .o_rdata(mem_rdata));

   always #4 i_clock = ~i_clock;

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("mismatches %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Requests only while the engine is idle, since busy ones are dropped silently
   task automatic send(input logic c, input logic r, input logic a,
                       input logic [FRAME_W-1:0] sz, input logic [FRAME_W-1:0] ob);
      int n;
      n = 0;
      while ((mem.valid !== 1'b0 || stall !== 1'b0) && n < 200) begin
         @(negedge i_clock);
         n++;
      end
      chk(64'(n == 200), 64'h0);
      req = '{call: c, ret: r, alloc: a, alloc_size: sz, out_base: ob};
      @(negedge i_clock);
      req = '0;
      // Quiet cycle, so the next request is never set in this time step
      @(negedge i_clock);
   endtask

   task automatic settle;
      int n;
      n = 0;
      while ((stall !== 1'b0 || mem.valid !== 1'b0) && n < 2000) begin
         @(negedge i_clock);
         n++;
      end
      chk(64'(n == 2000), 64'h0);
   endtask

   task automatic wr(input logic [VREG_W-1:0] v, input logic [DATA_W-1:0] d);
      wr_vreg = v;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge i_clock);
      wr_en = 1'b0;
   endtask

   // Read data is registered: seen one edge after the id is sampled
   task automatic rd_chk(input logic [VREG_W-1:0] v, input logic [DATA_W-1:0] exp);
      rd_vreg = v;
      @(negedge i_clock);
      chk(rd_data, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Memory traffic watch: stack order out, reverse order back; hang guard
   always @(negedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end else begin
         if (i_rst_n && mem.valid && mem_ack) begin
            if (mem.write) begin
               chk(64'(mem.addr), 64'(top[15:0]));
               top++;
               spills++;
            end else begin
               top--;
               chk(64'(mem.addr), 64'(top[15:0]));
            end
         end
         if (bg) begin
            chk(64'(stall), 64'h0);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(negedge i_clock);
      i_rst_n = 1'b1;
      chk(64'(base), 64'h0);
      chk(64'(stall), 64'h0);
      chk(64'(mem.valid), 64'h0);
      chk(64'(dirty), 64'h0);
      for (int i = 0; i < 4; i++) begin
         wr(row_v[i], row_d[i]);
         rd_chk(row_v[i], row_d[i]);
      end
      // Plain call and return, callee writes its own frame
      send(1'b1, 1'b0, 1'b0, 7'h08, 7'h08);
      chk(64'(base), 64'h8);
      chk(64'(dirty), 64'h8);
      wr(6'h00, 64'hC0DEC0DEC0DEC0DE);
      rd_chk(6'h00, 64'hC0DEC0DEC0DEC0DE);
      send(1'b0, 1'b1, 1'b0, 7'h00, 7'h00);
      chk(64'(base), 64'h0);
      rd_chk(row_v[0], row_d[0]);
      // Allocation of the whole file forces spill, slow memory
      slow = 1'b1;
      send(1'b1, 1'b0, 1'b0, 7'h08, 7'h08);
      send(1'b0, 1'b0, 1'b1, 7'h40, 7'h00);
      chk(64'(stall), 64'h1);
      settle();
      chk(64'(spills), 64'h8);
      slow = 1'b0;
      send(1'b0, 1'b1, 1'b0, 7'h00, 7'h00);
      chk(64'(stall), 64'h1);
      settle();
      chk(64'(base), 64'h0);
      for (int i = 0; i < 4; i++) begin
         rd_chk(row_v[i], row_d[i]);
      end
      // Background spill then fill must never stall the pipeline
      send(1'b1, 1'b0, 1'b0, 7'h08, 7'h08);
      bg = 1'b1;
      idle_spill = 1'b1;
      repeat (30) @(negedge i_clock);
      idle_spill = 1'b0;
      settle();
      chk(64'(dirty), 64'h0);
      chk(64'(spills), 64'h10);
      idle_fill = 1'b1;
      repeat (40) @(negedge i_clock);
      idle_fill = 1'b0;
      settle();
      chk(64'(dirty), 64'h8);
      chk(64'(top), 64'h0);
      bg = 1'b0;
      send(1'b0, 1'b1, 1'b0, 7'h00, 7'h00);
      settle();
      for (int i = 0; i < 4; i++) begin
         rd_chk(row_v[i], row_d[i]);
      end
      // Reset in mid-run drops the callee frame and clears the file
      send(1'b1, 1'b0, 1'b0, 7'h08, 7'h08);
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clock);
      i_rst_n = 1'b1;
      chk(64'(base), 64'h0);
      chk(64'(dirty), 64'h0);
      chk(64'(stall), 64'h0);
      rd_chk(row_v[1], 64'h0);
      stop_test();
   end
endmodule
`default_nettype wire
